// file: core/run_mode_unit_clock_gating.sv
// Run, sleep and deep-sleep clock gating control for peripheral units
`timescale 1ns/1ps
module run_mode_unit_clock_gating
   import clk_gate_pkg::*;
(
   // Clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  resetn_i,
   // APB slave
   input  wire logic                  psel_i,
   input  wire logic                  penable_i,
   input  wire logic                  pwrite_i,
   input  wire logic [31:0]           paddr_i,
   input  wire logic [31:0]           pwdata_i,
   output logic      [31:0]           prdata_o,
   output logic                       pready_o,
   output logic                       pslverr_o,
   // System power state
   input  wire logic                  sleep_i,
   input  wire logic                  deep_sleep_i,
   // Peripheral access check
   input  wire logic                  unit_req_i,
   input  wire logic [3:0]            unit_id_i,
   output logic                       unit_grant_o,
   output logic                       unit_fault_o,
   // Unit clocks
   output logic      [UNIT_COUNT-1:0] unit_clk_en_o,
   output logic      [UNIT_COUNT-1:0] unit_clk_o,
   // Interrupt
   output logic                       irq_o
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [31:0] run1;
      logic [31:0] run2;
      logic [31:0] sleep1;
      logic [31:0] sleep2;
      logic [31:0] deep1;
      logic [31:0] deep2;
      logic        auto_clock_gating;
      logic [31:0] irq_status;
      logic [31:0] irq_mask;
      unit_vec_t   unit_en;
      logic        ack;
      logic [31:0] prdata;
      logic        pslverr;
   } state_t;

   state_t q;
   state_t d;

   logic [11:0] ofs;
   logic        base_ok;
   logic        mapped;
   logic [31:0] rdata;
   logic        take;
   logic        commit_wr;
   logic [31:0] irq_set;
   logic [31:0] irq_clr;

   assign ofs     = paddr_i[11:0];
   assign base_ok = (paddr_i[31:12] == SYSCTL_BASE[31:12]);

   // ****************************************************************
   // Address decode and read mux
   // ****************************************************************
   // offset decode
   always_comb
   begin
      mapped = base_ok;
      rdata  = REG_RESET;
      unique case (ofs)
         RUN_CLOCK_CONFIG_OFS: rdata = {4'h0, q.auto_clock_gating, 27'h0};
         RUN_GATE_1_OFS:       rdata = q.run1;
         RUN_GATE_2_OFS:       rdata = q.run2;
         SLEEP_GATE_1_OFS:     rdata = q.sleep1;
         SLEEP_GATE_2_OFS:     rdata = q.sleep2;
         DEEP_GATE_1_OFS:      rdata = q.deep1;
         DEEP_GATE_2_OFS:      rdata = q.deep2;
         IRQ_STATUS_OFS:       rdata = q.irq_status;
         IRQ_MASK_OFS:         rdata = q.irq_mask;
         default:              mapped = 1'b0;
      endcase
   end

   assign take      = psel_i & penable_i & ~q.ack;
   assign commit_wr = psel_i & penable_i & q.ack & pwrite_i & mapped;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      d = q;
      // One wait state: read data is captured at the same edge that pready rises
      d.ack = take;
      if (take)
      begin
         d.prdata  = pwrite_i ? REG_RESET : rdata;
         d.pslverr = ~mapped;
      end

      if (commit_wr)
      begin
         unique case (ofs)
            RUN_CLOCK_CONFIG_OFS: d.auto_clock_gating    = pwdata_i[AUTO_CLOCK_GATING_BIT];
            RUN_GATE_1_OFS:       d.run1   = pwdata_i & GATE1_WMASK;
            RUN_GATE_2_OFS:       d.run2   = pwdata_i & GATE2_WMASK;
            SLEEP_GATE_1_OFS:     d.sleep1 = pwdata_i & GATE1_WMASK;
            SLEEP_GATE_2_OFS:     d.sleep2 = pwdata_i & GATE2_WMASK;
            DEEP_GATE_1_OFS:      d.deep1  = pwdata_i & GATE1_WMASK;
            DEEP_GATE_2_OFS:      d.deep2  = pwdata_i & GATE2_WMASK;
            IRQ_MASK_OFS:         d.irq_mask = pwdata_i & IRQ_WMASK;
            default:              d.auto_clock_gating    = q.auto_clock_gating;
         endcase
      end

      // Sticky events; a new event wins over a clear in the same cycle
      irq_set = REG_RESET;
      irq_set[IRQ_UNIT_FAULT_BIT] = unit_fault_o;
      irq_set[IRQ_DECODE_ERR_BIT] = take & ~mapped;
      irq_clr = (commit_wr && ofs == IRQ_STATUS_OFS) ? (pwdata_i & IRQ_WMASK) : REG_RESET;
      d.irq_status = (q.irq_status & ~irq_clr) | irq_set;

      // source of enables by power state
      d.unit_en = gather_enables(q.run1, q.run2);
      if (q.auto_clock_gating && deep_sleep_i)
      begin
         d.unit_en = gather_enables(q.deep1, q.deep2);
      end
      else if (q.auto_clock_gating && sleep_i)
      begin
         d.unit_en = gather_enables(q.sleep1, q.sleep2);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign prdata_o      = q.prdata;
   assign pready_o      = q.ack;
   assign pslverr_o     = q.ack & q.pslverr;
   assign irq_o         = |(q.irq_status & q.irq_mask);
   assign unit_clk_en_o = q.unit_en;

   unit_access_guard u_guard
   (
      .unit_en_i (q.unit_en),
      .req_i     (unit_req_i),
      .id_i      (unit_id_i),
      .grant_o   (unit_grant_o),
      .fault_o   (unit_fault_o)
   );

   for (genvar g = 0; g < UNIT_COUNT; g++)
   begin : g_gate
      unit_clock_gate u_gate
      (
         .clk_i  (clk_i),
         .en_i   (q.unit_en[g]),
         .gclk_o (unit_clk_o[g])
      );
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   logic wr_run1;
   logic wr_run2;
   assign wr_run1 = commit_wr && ofs == RUN_GATE_1_OFS;
   assign wr_run2 = commit_wr && ofs == RUN_GATE_2_OFS;

   reset_clear_a: assert property ($past(!resetn_i) |-> (unit_clk_en_o == '0) && q.run2 == '0)
      else $error("enables not clear after reset");
   timer_gate_a: assert property ((wr_run1 && !q.auto_clock_gating) |-> ##2
      unit_clk_en_o[IDX_GP_COUNTER2_CLK_EN] == $past(pwdata_i[GATE1_GP_COUNTER2_BIT], 2))
      else $error("timer enable does not follow write");
   two_wire_gate_a: assert property (!q.auto_clock_gating |=>
      unit_clk_en_o[IDX_TWO_WIRE0_CLK_EN] == $past(q.run1[GATE1_TWO_WIRE0_BIT]))
      else $error("two-wire enable wrong");
   sync_serial_a: assert property ((wr_run1 && !q.auto_clock_gating) |-> ##2
      unit_clk_en_o[IDX_SYNC_SERIAL0_CLK_EN] == $past(pwdata_i[GATE1_SYNC_SERIAL0_BIT], 2))
      else $error("sync serial enable wrong");
   async_serial_a: assert property (!q.auto_clock_gating |=>
      unit_clk_en_o[IDX_ASYNC_SERIAL1_CLK_EN] == $past(q.run1[GATE1_ASYNC_SERIAL1_BIT]) &&
      unit_clk_en_o[IDX_ASYNC_SERIAL0_CLK_EN] == $past(q.run1[GATE1_ASYNC_SERIAL0_BIT]))
      else $error("async serial enable wrong");
   net_phy_gate_a: assert property ((wr_run2 && !q.auto_clock_gating) |-> ##2
      unit_clk_en_o[IDX_NET_PHY0_CLK_EN] == $past(pwdata_i[GATE2_NET_PHY0_BIT], 2))
      else $error("phy enable wrong");
   net_mac_gate_a: assert property ((wr_run2 && !q.auto_clock_gating) |-> ##2
      unit_clk_en_o[IDX_NET_MAC0_CLK_EN] == $past(pwdata_i[GATE2_NET_MAC0_BIT], 2))
      else $error("mac enable wrong");
   port_g_gate_a: assert property ((wr_run2 && !q.auto_clock_gating) |-> ##2
      unit_clk_en_o[IDX_PORT_G_CLK_EN] == $past(pwdata_i[GATE2_PORT_G_BIT], 2))
      else $error("port G enable wrong");
   fault_answer_a: assert property ((unit_req_i && unit_id_i == 4'h8 &&
      !unit_clk_en_o[IDX_NET_PHY0_CLK_EN]) |-> unit_fault_o && !unit_grant_o
      ##1 q.irq_status[IRQ_UNIT_FAULT_BIT])
      else $error("no fault on unclocked access");
   reserved_zero_a: assert property ((pready_o && !pwrite_i && ofs == RUN_GATE_2_OFS) |->
      (prdata_o & ~GATE2_WMASK) == '0)
      else $error("reserved bits not zero");
   gate2_decode_a: assert property ((take && paddr_i == (SYSCTL_BASE | 32'(RUN_GATE_2_OFS)))
      |=> pready_o && !pslverr_o)
      else $error("gate 2 not decoded");
   sleep_select_a: assert property ((q.auto_clock_gating && sleep_i && !deep_sleep_i) |=>
      unit_clk_en_o == gather_enables($past(q.sleep1), $past(q.sleep2)))
      else $error("sleep enables not applied");
   no_acg_run_a: assert property ((!q.auto_clock_gating && (sleep_i || deep_sleep_i)) |=>
      unit_clk_en_o == gather_enables($past(q.run1), $past(q.run2)))
      else $error("run enables lost without auto gating");
   apb_ready_a: assert property (take |=> pready_o ##1 !pready_o)
      else $error("pready not one cycle after access");

   fault_seen_c: cover property (unit_req_i && unit_fault_o ##1 irq_o);
   deep_sleep_c: cover property (q.auto_clock_gating && deep_sleep_i ##1 unit_clk_en_o != '0);
   bad_addr_c:   cover property (pready_o && pslverr_o);
endmodule

// file: core/unit_access_guard.sv
// Decides whether an access to a peripheral unit is served or faulted
`timescale 1ns/1ps
module unit_access_guard
   import clk_gate_pkg::*;
(
   // Unit state
   input  wire logic      [UNIT_COUNT-1:0] unit_en_i,
   // Access request
   input  wire logic                       req_i,
   input  wire logic      [3:0]            id_i,
   // Answer
   output logic                            grant_o,
   output logic                            fault_o
);
   function automatic logic unit_on(input unit_vec_t en, input unit_id_t id);
      logic r;
      r = 1'b0;
      if (32'(id) < UNIT_COUNT)
      begin
         r = en[id];
      end
      return r;
   endfunction

   assign fault_o = req_i & ~unit_on(unit_en_i, id_i);
   assign grant_o = req_i &  unit_on(unit_en_i, id_i);
endmodule

// file: core/unit_clock_gate.sv
// Glitch-free clock gate for one controlled unit
`timescale 1ns/1ps
module unit_clock_gate
(
   // Clock and enable
   input  wire logic clk_i,
   input  wire logic en_i,
   // Gated clock
   output logic      gclk_o
);
   logic en_l;

   always_latch
   begin
      if (!clk_i)
      begin
         en_l <= en_i;
      end
   end

   assign gclk_o = clk_i & en_l;
endmodule

// file: include/clk_gate_pkg.sv
// Constants, register map and enable gathering for the unit clock gating block
package clk_gate_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [31:0] SYSCTL_BASE          = 32'h400F_E000;
   localparam logic [11:0] RUN_CLOCK_CONFIG_OFS = 12'h060;
   localparam logic [11:0] RUN_GATE_1_OFS       = 12'h104;
   localparam logic [11:0] RUN_GATE_2_OFS       = 12'h108;
   localparam logic [11:0] SLEEP_GATE_1_OFS     = 12'h114;
   localparam logic [11:0] SLEEP_GATE_2_OFS     = 12'h118;
   localparam logic [11:0] DEEP_GATE_1_OFS      = 12'h124;
   localparam logic [11:0] DEEP_GATE_2_OFS      = 12'h128;
   localparam logic [11:0] IRQ_STATUS_OFS       = 12'h1F0;
   localparam logic [11:0] IRQ_MASK_OFS         = 12'h1F4;

   localparam logic [31:0] REG_RESET    = 32'h0000_0000;
   localparam logic [31:0] GATE1_WMASK  = 32'h000F_1013;
   localparam logic [31:0] GATE2_WMASK  = 32'h5000_0040;
   localparam logic [31:0] RCC_WMASK    = 32'h0800_0000;
   localparam logic [31:0] IRQ_WMASK    = 32'h0000_0003;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int GATE1_GP_COUNTER3_BIT = 19;
   localparam int GATE1_GP_COUNTER2_BIT = 18;
   localparam int GATE1_GP_COUNTER1_BIT = 17;
   localparam int GATE1_GP_COUNTER0_BIT = 16;
   localparam int GATE1_TWO_WIRE0_BIT   = 12;
   localparam int GATE1_SYNC_SERIAL0_BIT = 4;
   localparam int GATE1_ASYNC_SERIAL1_BIT = 1;
   localparam int GATE1_ASYNC_SERIAL0_BIT = 0;
   localparam int GATE2_NET_PHY0_BIT    = 30;
   localparam int GATE2_NET_MAC0_BIT    = 28;
   localparam int GATE2_PORT_G_BIT      = 6;
   localparam int AUTO_CLOCK_GATING_BIT = 27;
   localparam int IRQ_UNIT_FAULT_BIT    = 0;
   localparam int IRQ_DECODE_ERR_BIT    = 1;

   // ****************************************************************
   // Unit enable vector
   // ****************************************************************
   localparam int UNIT_COUNT             = 11;
   localparam int IDX_GP_COUNTER0_CLK_EN = 0;
   localparam int IDX_GP_COUNTER1_CLK_EN = 1;
   localparam int IDX_GP_COUNTER2_CLK_EN = 2;
   localparam int IDX_GP_COUNTER3_CLK_EN = 3;
   localparam int IDX_TWO_WIRE0_CLK_EN   = 4;
   localparam int IDX_SYNC_SERIAL0_CLK_EN = 5;
   localparam int IDX_ASYNC_SERIAL0_CLK_EN = 6;
   localparam int IDX_ASYNC_SERIAL1_CLK_EN = 7;
   localparam int IDX_NET_PHY0_CLK_EN    = 8;
   localparam int IDX_NET_MAC0_CLK_EN    = 9;
   localparam int IDX_PORT_G_CLK_EN      = 10;

   typedef logic [UNIT_COUNT-1:0] unit_vec_t;
   typedef logic [3:0]            unit_id_t;

   // Maps the two gating words onto the unit enable vector
   function automatic unit_vec_t gather_enables(input logic [31:0] g1,
                                                input logic [31:0] g2);
      unit_vec_t v;
      v                           = '0;
      v[IDX_GP_COUNTER0_CLK_EN]   = g1[GATE1_GP_COUNTER0_BIT];
      v[IDX_GP_COUNTER1_CLK_EN]   = g1[GATE1_GP_COUNTER1_BIT];
      v[IDX_GP_COUNTER2_CLK_EN]   = g1[GATE1_GP_COUNTER2_BIT];
      v[IDX_GP_COUNTER3_CLK_EN]   = g1[GATE1_GP_COUNTER3_BIT];
      v[IDX_TWO_WIRE0_CLK_EN]     = g1[GATE1_TWO_WIRE0_BIT];
      v[IDX_SYNC_SERIAL0_CLK_EN]  = g1[GATE1_SYNC_SERIAL0_BIT];
      v[IDX_ASYNC_SERIAL0_CLK_EN] = g1[GATE1_ASYNC_SERIAL0_BIT];
      v[IDX_ASYNC_SERIAL1_CLK_EN] = g1[GATE1_ASYNC_SERIAL1_BIT];
      v[IDX_NET_PHY0_CLK_EN]      = g2[GATE2_NET_PHY0_BIT];
      v[IDX_NET_MAC0_CLK_EN]      = g2[GATE2_NET_MAC0_BIT];
      v[IDX_PORT_G_CLK_EN]        = g2[GATE2_PORT_G_BIT];
      return v;
   endfunction

endpackage

// file: tb/run_mode_unit_clock_gating_tb.sv
// Self-checking bench for the unit clock gating block
`timescale 1ns/1ps
module run_mode_unit_clock_gating_tb;
   import clk_gate_pkg::*;

   // ********
   // Stimulus, outputs and model state
   // ********
   localparam logic [31:0] M1 = 32'h000F1013;
   localparam logic [31:0] M2 = 32'h50000040;
   localparam logic [11:0] OFS [9] = '{RUN_CLOCK_CONFIG_OFS, RUN_GATE_1_OFS,
      RUN_GATE_2_OFS, SLEEP_GATE_1_OFS, SLEEP_GATE_2_OFS, DEEP_GATE_1_OFS,
      DEEP_GATE_2_OFS, IRQ_STATUS_OFS, IRQ_MASK_OFS};
   logic        clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        psel_i = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i = 1'b0;
   logic [31:0] paddr_i = '0;
   logic [31:0] pwdata_i = '0;
   logic        sleep_i = 1'b0;
   logic        deep_sleep_i = 1'b0;
   logic        unit_req_i = 1'b0;
   logic [3:0]  unit_id_i = '0;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic        unit_grant_o;
   logic        unit_fault_o;
   unit_vec_t   unit_clk_en_o;
   unit_vec_t   unit_clk_o;
   logic        irq_o;
   logic [31:0] g1, g2, s1, s2, d1, d2, st, rd;
   logic        auto_clock_gating;
   logic        er;
   int          errors = 0;
   int          n_checks = 0;
   int          cycles = 0;

   always #25 clk_i = ~clk_i;

   run_mode_unit_clock_gating i_run_mode_unit_clock_gating
   (
      .clk_i        (clk_i),
      .resetn_i     (resetn_i),
      .psel_i       (psel_i),
      .penable_i    (penable_i),
      .pwrite_i     (pwrite_i),
      .paddr_i      (paddr_i),
      .pwdata_i     (pwdata_i),
      .prdata_o     (prdata_o),
      .pready_o     (pready_o),
      .pslverr_o    (pslverr_o),
      .sleep_i      (sleep_i),
      .deep_sleep_i (deep_sleep_i),
      .unit_req_i   (unit_req_i),
      .unit_id_i    (unit_id_i),
      .unit_grant_o (unit_grant_o),
      .unit_fault_o (unit_fault_o),
      .unit_clk_en_o(unit_clk_en_o),
      .unit_clk_o   (unit_clk_o),
      .irq_o        (irq_o)
   );

   // ********
   // Expectations and tasks
   // ********
   function automatic unit_vec_t map_en(input logic [31:0] a, input logic [31:0] b);
      return {b[6], b[28], b[30], a[1], a[0], a[4], a[12], a[19], a[18], a[17], a[16]};
   endfunction

   function automatic unit_vec_t eff();
      if (auto_clock_gating && deep_sleep_i)
         return map_en(d1, d2);
      if (auto_clock_gating && sleep_i)
         return map_en(s1, s2);
      return map_en(g1, g2);
   endfunction

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_checks++;
      if (got !== ex)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic stop_test();
      $display("Checks %0d, errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      // Look at pready in mid-cycle, where the registered answer has settled
      do
      begin
         @(negedge clk_i);
         n++;
      end
      while (pready_o !== 1'b1 && n < 50);
      if (pready_o !== 1'b1)
      begin
         errors++;
         $display("BAD pready expected 1 seen %b", pready_o);
         stop_test();
      end
      rd = prdata_o;
      er = pslverr_o;
      // The transfer completes at this edge; only then is the request released
      @(posedge clk_i);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] o, input logic [31:0] d);
      apb(1'b1, SYSCTL_BASE | {20'h0, o}, d);
   endtask

   task automatic rdc(input string nm, input logic [11:0] o, input logic [31:0] ex);
      apb(1'b0, SYSCTL_BASE | {20'h0, o}, '0);
      chk(nm, ex, rd);
   endtask

   task automatic en_chk();
      repeat (2) @(posedge clk_i);
      #1;
      chk("unit enables", {21'h0, eff()}, {21'h0, unit_clk_en_o});
      chk("gated clocks high", {21'h0, eff()}, {21'h0, unit_clk_o});
      @(negedge clk_i);
      #1;
      chk("gated clocks low", 32'h0, {21'h0, unit_clk_o});
   endtask

   task automatic acc(input int id);
      unit_vec_t v;
      logic      ok;
      @(posedge clk_i);
      unit_req_i <= 1'b1;
      unit_id_i <= id[3:0];
      #1;
      v = eff();
      ok = (id < UNIT_COUNT) ? v[id] : 1'b0;
      chk("grant", {31'h0, ok}, {31'h0, unit_grant_o});
      chk("fault", {31'h0, !ok}, {31'h0, unit_fault_o});
      if (!ok)
         st[0] = 1'b1;
      @(posedge clk_i);
      unit_req_i <= 1'b0;
   endtask

   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         errors = errors + 1;
         stop_test();
      end
   end

   // ********
   // Main sequence
   // ********
   initial
   begin
      {g1, g2, s1, s2, d1, d2, st} = '0;
      auto_clock_gating = 1'b0;
      void'($urandom(32'h059B5166));
      repeat (12) @(posedge clk_i);
      resetn_i <= 1'b1;
      for (int i = 0; i < 9; i++)
         rdc("reset value", OFS[i], 32'h0);
      en_chk();
      for (int b = 0; b < 32; b++)
      begin
         wr(RUN_GATE_1_OFS, 32'h1 << b);
         wr(RUN_GATE_2_OFS, 32'h1 << b);
         g1 = (32'h1 << b) & M1;
         g2 = (32'h1 << b) & M2;
         rdc("gate 1", RUN_GATE_1_OFS, g1);
         rdc("gate 2", RUN_GATE_2_OFS, g2);
         en_chk();
      end
      for (int k = 0; k < 8; k++)
      begin
         g1 = (k < 2) ? {32{k == 0}} : $urandom;
         g2 = (k < 2) ? {32{k == 0}} : $urandom;
         wr(RUN_GATE_1_OFS, g1);
         wr(RUN_GATE_2_OFS, g2);
         g1 &= M1;
         g2 &= M2;
         en_chk();
         for (int id = 0; id < 16; id++)
            acc(id);
      end
      rdc("status", IRQ_STATUS_OFS, st);
      chk("irq masked", 32'h0, {31'h0, irq_o});
      apb(1'b0, SYSCTL_BASE | 32'h200, '0);
      chk("decode err", 32'h1, {31'h0, er});
      chk("decode rdata", 32'h0, rd);
      apb(1'b1, 32'h4000_0104, '1);
      chk("base err", 32'h1, {31'h0, er});
      rdc("gate 1 kept", RUN_GATE_1_OFS, g1);
      st[1] = 1'b1;
      wr(IRQ_MASK_OFS, 32'h3);
      repeat (2) @(posedge clk_i);
      chk("irq set", 32'h1, {31'h0, irq_o});
      wr(IRQ_STATUS_OFS, 32'h3);
      st = '0;
      rdc("status clear", IRQ_STATUS_OFS, st);
      chk("irq clear", 32'h0, {31'h0, irq_o});
      wr(IRQ_MASK_OFS, 32'h2);
      acc(15);
      rdc("mask", IRQ_MASK_OFS, 32'h2);
      chk("irq off", 32'h0, {31'h0, irq_o});
      rdc("status fault", IRQ_STATUS_OFS, 32'h1);
      s1 = $urandom & M1;
      s2 = $urandom & M2;
      d1 = $urandom & M1;
      d2 = $urandom & M2;
      wr(SLEEP_GATE_1_OFS, s1);
      wr(SLEEP_GATE_2_OFS, s2);
      wr(DEEP_GATE_1_OFS, d1);
      wr(DEEP_GATE_2_OFS, d2);
      @(posedge clk_i);
      sleep_i <= 1'b1;
      en_chk();
      wr(RUN_CLOCK_CONFIG_OFS, 32'h0800_0000);
      auto_clock_gating = 1'b1;
      rdc("config", RUN_CLOCK_CONFIG_OFS, 32'h0800_0000);
      en_chk();
      @(posedge clk_i);
      deep_sleep_i <= 1'b1;
      en_chk();
      for (int id = 0; id < 11; id++)
         acc(id);
      @(posedge clk_i);
      sleep_i <= 1'b0;
      en_chk();
      @(posedge clk_i);
      deep_sleep_i <= 1'b0;
      en_chk();
      stop_test();
   end
endmodule
